// ===== verilog/uac_pkg.sv
// package: register map, field layout, reset values, states and carriers of the serial core
package uac_pkg;
    // cpu memory addresses
    localparam logic [15:0] ADDR_MODE   = 16'hff90;
    localparam logic [15:0] ADDR_BAUD   = 16'hff91;
    localparam logic [15:0] ADDR_DATA   = 16'hff92;  // receive buffer on read, transmit data on write
    localparam logic [15:0] ADDR_STATUS = 16'hff93;

    // reset values
    localparam logic [7:0] MODE_RESET   = 8'h01;
    localparam logic [7:0] BAUD_RESET   = 8'h1f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;

    // baud register fields
    localparam int unsigned BAUD_SEL_HI = 7;
    localparam int unsigned BAUD_SEL_LO = 6;
    localparam int unsigned BAUD_DIV_HI = 4;
    localparam logic [7:0]  BAUD_MASK   = 8'hdf;  // bit 5 reads zero
    localparam logic [4:0]  DIV_MIN     = 5'h08;  // smallest legal divisor k

    // divider input clock selections
    localparam logic [1:0] SEL_X4      = 2'h0;
    localparam logic [1:0] SEL_X1      = 2'h1;
    localparam logic [1:0] SEL_HALF    = 2'h2;
    localparam logic [1:0] SEL_QUARTER = 2'h3;
    localparam logic [1:0] PRE_QUARTER = 2'h3;

    // parity modes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // character lengths, last bit index
    localparam logic [2:0] LAST_BIT_7 = 3'h6;
    localparam logic [2:0] LAST_BIT_8 = 3'h7;
    localparam logic [7:0] MASK_7     = 8'h7f;

    // mode register layout, msb first
    typedef struct packed {
        logic       power;
        logic       transmit_enable_bit;
        logic       receive_enable_bit;
        logic [1:0] parity_select;
        logic       character_length_bit;
        logic       stop_length_bit;
        logic       error_irq_routing_bit;
    } uac_mode_t;

    // receive error flags, in status register order
    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_flag;
    } uac_errors_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} uac_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uac_rx_state_t;
endpackage

// ===== verilog/uac_core.sv
// serial core: mode, baud and status registers, baud generator, transmitter and receiver
//
// Behaviour
// - master enable clear stops and resets the core
// - transmit and receive enables pick pin functions
// - two-bit select: none, zero, odd, even parity
// - transmitter sends one or two stop bits
// - receiver checks only one stop bit
// - routing bit clear: error interrupt, no completion on error
// - routing bit set: completion interrupt, no error
// - transmit pin low when disabled, high enabled
// - status: bits 2..0 parity, framing, overrun
// - odd or even parity mismatch sets parity error flag; zero parity bit is not checked
// - missing stop bit sets framing error flag
// - unread buffer flags overrun on every frame
// - overrun frame discarded, buffer keeps old data
// - baud register resets 0x1f, bit 5 zero
// - clock select: four times, one, half, quarter
// - divisor k from 8 to 31 only
// - bit rate is input clock over 2k
// - frame: start, 7/8 data, parity, stops
// - seven-bit mode ignores and zeroes bit 7
// - even parity makes total ones even
// - odd parity makes total ones odd
// - buffer read or next frame clears flags
// - start bit confirmed after half bit resample
`timescale 1ns/100ps
module uac_core (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // subsystem clock ticks, one-cycle pulses from on-chip clock logic
    input  wire logic        xt_tick,
    input  wire logic        xt4_tick,
    // cpu memory access
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    // serial pins and their function selects
    input  wire logic        serial_rx_pin,
    output logic             serial_tx_pin,
    output logic             tx_serial_sel,
    output logic             rx_serial_sel,
    // interrupt request pulses
    output logic             transmit_done_irq,
    output logic             receive_done_irq,
    output logic             receive_error_irq
);
    import uac_pkg::*;

    logic [7:0]    mode_q;
    uac_mode_t     mode;
    logic [7:0]    baud_q;
    uac_errors_t   errors;
    logic [7:0]    receive_buffer;
    logic          rx_full;
    logic [1:0]    pre_cnt;
    logic          divider_input_clock_tick;
    logic [4:0]    div_k;
    logic [5:0]    bit_limit;
    logic          active;
    uac_tx_state_t tx_state;
    logic [7:0]    tx_shift;
    logic [2:0]    tx_idx;
    logic [5:0]    tx_cnt;
    logic          tx_par;
    logic          tx_write;
    uac_rx_state_t rx_state;
    logic [7:0]    rx_shift;
    logic [2:0]    rx_idx;
    logic [5:0]    rx_cnt;
    logic [5:0]    rx_limit;
    logic          rx_par;
    logic          rx_meta;
    logic          rx_sync;
    logic          rx_prev;
    logic          rx_sample;
    logic          frame_done;
    logic          frame_perr;
    logic          frame_ferr;
    logic          buf_read;
    logic [2:0]    last_bit;

    assign mode     = uac_mode_t'(mode_q);
    assign active   = mode.power;
    assign last_bit = mode.character_length_bit ? LAST_BIT_8 : LAST_BIT_7;
    assign buf_read = cpu_rd && (cpu_addr == ADDR_DATA);

    // register writes; baud rewrites are trusted to happen with the core disabled
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= MODE_RESET;
            baud_q <= BAUD_RESET;
        end else if (cpu_wr) begin
            if (cpu_addr == ADDR_MODE)
                mode_q <= cpu_wdata;
            if (cpu_addr == ADDR_BAUD)
                baud_q <= cpu_wdata & BAUD_MASK;
        end
    end

    // registered read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_rdata <= DATA_RESET;
        end else if (cpu_rd) begin
            case (cpu_addr)
                ADDR_MODE:   cpu_rdata <= mode_q;
                ADDR_BAUD:   cpu_rdata <= baud_q;
                ADDR_DATA:   cpu_rdata <= receive_buffer;
                ADDR_STATUS: cpu_rdata <= {5'h00, errors};
                default:     cpu_rdata <= DATA_RESET;
            endcase
        end
    end

    // divider input clock; the quadruple clock stalls in halt, so software avoids it there
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            pre_cnt   <= 2'h0;
            divider_input_clock_tick <= 1'b0;
        end else begin
            if (xt_tick)
                pre_cnt <= pre_cnt + 2'h1;
            case (baud_q[BAUD_SEL_HI:BAUD_SEL_LO])
                SEL_X4:      divider_input_clock_tick <= xt4_tick;
                SEL_X1:      divider_input_clock_tick <= xt_tick;
                SEL_HALF:    divider_input_clock_tick <= xt_tick && pre_cnt[0];
                SEL_QUARTER: divider_input_clock_tick <= xt_tick && (pre_cnt == PRE_QUARTER);
                default:     divider_input_clock_tick <= 1'b0;
            endcase
        end
    end

    // prohibited small divisors are raised to the minimum rather than running too fast
    assign div_k     = (baud_q[BAUD_DIV_HI:0] < DIV_MIN) ? DIV_MIN : baud_q[BAUD_DIV_HI:0];
    assign bit_limit = {div_k, 1'b0} - 6'h01;

    // transmitter
    assign tx_write = cpu_wr && (cpu_addr == ADDR_DATA) && mode.transmit_enable_bit && tx_state == TX_IDLE;

    always_ff @(posedge clk) begin
        if (reset || !active) begin
            tx_state          <= TX_IDLE;
            tx_shift          <= DATA_RESET;
            tx_idx            <= 3'h0;
            tx_cnt            <= 6'h00;
            tx_par            <= 1'b0;
            transmit_done_irq <= 1'b0;
        end else begin
            transmit_done_irq <= 1'b0;
            if (tx_write) begin
                tx_shift <= mode.character_length_bit ? cpu_wdata : (cpu_wdata & MASK_7);
                case (mode.parity_select)
                    PAR_EVEN: tx_par <= ^(mode.character_length_bit ? cpu_wdata : (cpu_wdata & MASK_7));
                    PAR_ODD:  tx_par <= ~^(mode.character_length_bit ? cpu_wdata : (cpu_wdata & MASK_7));
                    default:  tx_par <= 1'b0;
                endcase
                tx_idx   <= 3'h0;
                tx_cnt   <= 6'h00;
                tx_state <= TX_START;
            end else if (tx_state != TX_IDLE && divider_input_clock_tick) begin
                if (tx_cnt != bit_limit) begin
                    tx_cnt <= tx_cnt + 6'h01;
                end else begin
                    tx_cnt <= 6'h00;
                    case (tx_state)
                        TX_START: tx_state <= TX_DATA;
                        TX_DATA: begin
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_idx   <= tx_idx + 3'h1;
                            if (tx_idx == last_bit)
                                tx_state <= (mode.parity_select == PAR_NONE) ? TX_STOP1 : TX_PARITY;
                        end
                        TX_PARITY: tx_state <= TX_STOP1;
                        TX_STOP1: begin
                            tx_state          <= mode.stop_length_bit ? TX_STOP2 : TX_IDLE;
                            transmit_done_irq <= !mode.stop_length_bit;
                        end
                        TX_STOP2: begin
                            tx_state          <= TX_IDLE;
                            transmit_done_irq <= 1'b1;
                        end
                        default: tx_state <= TX_IDLE;
                    endcase
                end
            end
        end
    end

    // transmit pin: low while disabled, idle high once enabled
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            serial_tx_pin <= 1'b0;
        end else begin
            case (tx_state)
                TX_START:  serial_tx_pin <= 1'b0;
                TX_DATA:   serial_tx_pin <= tx_shift[0];
                TX_PARITY: serial_tx_pin <= tx_par;
                default:   serial_tx_pin <= 1'b1;
            endcase
        end
    end

    // pin function selects follow the enable bits
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_serial_sel <= 1'b0;
            rx_serial_sel <= 1'b0;
        end else begin
            tx_serial_sel <= active && mode.transmit_enable_bit;
            rx_serial_sel <= active && mode.receive_enable_bit;
        end
    end

    // receive pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= serial_rx_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // receiver: half bit to the start centre, then a full bit per sample
    assign rx_limit  = (rx_state == RX_START) ? ({1'b0, div_k} - 6'h01) : bit_limit;
    assign rx_sample = divider_input_clock_tick && (rx_cnt == rx_limit);

    always_ff @(posedge clk) begin
        if (reset || !active || !mode.receive_enable_bit) begin
            rx_state <= RX_IDLE;
            rx_shift <= DATA_RESET;
            rx_idx   <= 3'h0;
            rx_cnt   <= 6'h00;
            rx_par   <= 1'b0;
        end else begin
            if (rx_state == RX_IDLE) begin
                rx_cnt <= 6'h00;
                if (rx_prev && !rx_sync)
                    rx_state <= RX_START;
            end else if (divider_input_clock_tick) begin
                rx_cnt <= rx_sample ? 6'h00 : rx_cnt + 6'h01;
            end
            if (rx_sample) begin
                case (rx_state)
                    RX_START: begin
                        rx_idx   <= 3'h0;
                        rx_shift <= DATA_RESET;
                        rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: begin
                        rx_shift[rx_idx] <= rx_sync;
                        rx_idx           <= rx_idx + 3'h1;
                        if (rx_idx == last_bit)
                            rx_state <= (mode.parity_select == PAR_NONE) ? RX_STOP : RX_PARITY;
                    end
                    RX_PARITY: begin
                        rx_par   <= rx_sync;
                        rx_state <= RX_STOP;
                    end
                    RX_STOP: rx_state <= RX_IDLE;
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // frame outcome at the single checked stop bit
    assign frame_done = rx_sample && rx_state == RX_STOP;
    assign frame_ferr = !rx_sync;
    always_comb begin
        case (mode.parity_select)
            PAR_EVEN: frame_perr = ^{rx_shift, rx_par};
            PAR_ODD:  frame_perr = ~^{rx_shift, rx_par};
            default:  frame_perr = 1'b0;
        endcase
    end

    // buffer, flags and reception interrupts; a completing frame wins over a buffer read
    always_ff @(posedge clk) begin
        if (reset || !active) begin
            receive_buffer    <= DATA_RESET;
            rx_full           <= 1'b0;
            errors            <= uac_errors_t'(STATUS_RESET[2:0]);
            receive_done_irq  <= 1'b0;
            receive_error_irq <= 1'b0;
        end else begin
            receive_done_irq  <= 1'b0;
            receive_error_irq <= 1'b0;
            if (frame_done) begin
                if (!rx_full) begin
                    receive_buffer <= rx_shift;
                    rx_full        <= 1'b1;
                end
                errors <= '{parity_error_flag:  frame_perr,
                            framing_error_flag: frame_ferr,
                            overrun_flag:       rx_full};
                if ((frame_perr || frame_ferr || rx_full) && !mode.error_irq_routing_bit)
                    receive_error_irq <= 1'b1;
                else
                    receive_done_irq <= 1'b1;
            end else if (buf_read) begin
                rx_full <= 1'b0;
                errors  <= uac_errors_t'(STATUS_RESET[2:0]);
            end
        end
    end
endmodule // uac_core

// ===== sim/uac_core_checker.sv
// checker: port-level properties of the serial core
`timescale 1ns/100ps
module uac_core_checker
    import uac_pkg::*;
(
    // clock, reset and cpu bus
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    // pins and interrupts
    input wire logic        serial_tx_pin,
    input wire logic        tx_serial_sel,
    input wire logic        rx_serial_sel,
    input wire logic        transmit_done_irq,
    input wire logic        receive_done_irq,
    input wire logic        receive_error_irq
);
    logic [7:0] mode_seen;
    logic [7:0] baud_seen;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // shadow of cpu writes, so no probe into the core is needed
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_seen <= MODE_RESET;
            baud_seen <= BAUD_RESET;
        end else if (cpu_wr && cpu_addr == ADDR_MODE) begin
            mode_seen <= cpu_wdata;
        end else if (cpu_wr && cpu_addr == ADDR_BAUD) begin
            baud_seen <= cpu_wdata;
        end
    end
    sequence s_off;
        !mode_seen[7] [*2];
    endsequence
    sequence s_rd(logic [15:0] a);
        cpu_rd && !cpu_wr && cpu_addr == a;
    endsequence
    property p_tx_low; s_off |-> !serial_tx_pin; endproperty
    property p_sel;
        $stable(mode_seen) |-> tx_serial_sel == (mode_seen[7] & mode_seen[6])
            && rx_serial_sel == (mode_seen[7] & mode_seen[5]);
    endproperty
    property p_err_route; receive_error_irq |-> !mode_seen[0]; endproperty
    property p_irq_excl; receive_done_irq |-> !receive_error_irq ##1 !receive_done_irq; endproperty
    property p_status_zero; s_rd(ADDR_STATUS) |=> cpu_rdata[7:3] == 5'h00; endproperty
    property p_baud_read; s_rd(ADDR_BAUD) |=> cpu_rdata == ($past(baud_seen) & BAUD_MASK); endproperty
    property p_off_quiet; s_off |-> !(transmit_done_irq || receive_done_irq || receive_error_irq); endproperty
    property p_tx_done; transmit_done_irq |-> serial_tx_pin ##1 !transmit_done_irq; endproperty
    a_tx_low: assert property (p_tx_low) else $error("tx pin high while off");
    a_sel: assert property (p_sel) else $error("pin select mismatch");
    a_err_route: assert property (p_err_route) else $error("error irq with routing set");
    a_irq_excl: assert property (p_irq_excl) else $error("receive irqs overlap");
    a_status_zero: assert property (p_status_zero) else $error("status upper bits set");
    a_baud_read: assert property (p_baud_read) else $error("baud readback wrong");
    a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
    a_tx_done: assert property (p_tx_done) else $error("tx done not at idle line");
endmodule // uac_core_checker

bind uac_core uac_core_checker i_chk (.clk(clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .serial_tx_pin(serial_tx_pin),
    .tx_serial_sel(tx_serial_sel), .rx_serial_sel(rx_serial_sel), .transmit_done_irq(transmit_done_irq),
    .receive_done_irq(receive_done_irq), .receive_error_irq(receive_error_irq));

// ===== sim/uac_station.sv
// remote serial station: drives the receive line, samples the transmit line
`timescale 1ns/100ps
module uac_station (
    // clock
    input wire logic clk,
    // serial lines
    input wire logic serial_tx_pin,
    output logic     serial_rx_pin
);
    // line idles high between frames
    initial serial_rx_pin = 1'b1;
    // send n bits lsb first, each bc cycles, then idle two bit times
    task automatic send(input logic [11:0] bits, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            serial_rx_pin <= bits[i];
            repeat (bc) @(posedge clk);
        end
        serial_rx_pin <= 1'b1;
        repeat (2 * bc) @(posedge clk);
    endtask
    // wait for a start edge, then sample mid-bit; bounded so a dead pin cannot hang
    task automatic catch(input int n, input int bc, output logic [11:0] bits);
        int w;
        bits = '0;
        w = 0;
        while (serial_tx_pin !== 1'b0 && w < 5000) begin
            @(posedge clk);
            w++;
        end
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = serial_tx_pin;
            if (i < n - 1) repeat (bc) @(posedge clk);
        end
    endtask
endmodule // uac_station

// ===== sim/uac_core_tb.sv
// testbench: registers, pins, transmit and receive frames of the serial core
`timescale 1ns/100ps
module uac_core_tb;
    import uac_pkg::*;
    logic        clk, reset, xt_tick, xt4_tick, cpu_wr, cpu_rd, serial_rx_pin, full;
    logic        serial_tx_pin, tx_serial_sel, rx_serial_sel, transmit_done_irq, receive_done_irq, receive_error_irq;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, rv, held, m;
    logic [11:0] fb, got;
    logic [1:0]  tick_cnt = 2'h0;
    int          n_mismatch = 0, check_count = 0, cycles = 0, n_done = 0, n_err = 0, bc, nb, w, k, sel, p;
    integer      seed = 32'hdeacf0a2;
    logic [31:0] r;

    uac_core i_dut (.clk(clk), .reset(reset), .xt_tick(xt_tick), .xt4_tick(xt4_tick), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .tx_serial_sel(tx_serial_sel),
        .rx_serial_sel(rx_serial_sel), .transmit_done_irq(transmit_done_irq),
        .receive_done_irq(receive_done_irq), .receive_error_irq(receive_error_irq));
    uac_station i_station (.clk(clk), .serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // plain tick every fourth cycle, irq counting, and the hang limit
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        xt_tick  <= (tick_cnt == 2'h3);
        cycles   <= cycles + 1;
        if (receive_done_irq) n_done <= n_done + 1;
        if (receive_error_irq) n_err <= n_err + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge clk);
        cpu_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge clk);
        cpu_rd   <= 1'b0;
        @(posedge clk);
        #1 d = cpu_rdata;
    endtask
    // baud is only rewritten with the core switched off
    task automatic cfg(input logic [7:0] mv, input logic [7:0] b);
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_BAUD, b);
        wr(ADDR_MODE, mv);
    endtask
    // expected frame bits lsb first; n returns the bit count
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] mv, output int n);
        logic [7:0] v;
        v = mv[2] ? d : (d & MASK_7);
        frame = mv[2] ? {3'h7, v, 1'b0} : {4'hf, v[6:0], 1'b0};
        n = mv[2] ? 9 : 8;
        if (mv[4:3] != PAR_NONE) begin
            frame[n] = (mv[4:3] == PAR_EVEN) ? ^v : (mv[4:3] == PAR_ODD) ? ~^v : 1'b0;
            n++;
        end
        n = n + 1 + mv[1];
        // bits past the last stop stay zero, as the catcher leaves them
        frame = frame & ((12'h001 << n) - 12'h001);
    endfunction
    // one received frame, optionally with a broken parity or stop bit
    task automatic rx_case(input logic [7:0] mv, input logic bp, input logic bs, input logic rdb);
        logic [7:0] d, st;
        int n, de, ee;
        d = 8'($random(seed));
        fb = frame(d, mv, n);
        if (bp) fb[n - 2 - mv[1]] = ~fb[n - 2 - mv[1]];
        if (bs) fb[n - 1 - mv[1]] = 1'b0;
        st = {5'h00, bp && mv[4], bs, full};
        de = n_done;
        ee = n_err;
        wr(ADDR_MODE, mv);
        i_station.send(fb, n - mv[1], bc);
        chk(12'(n_err - ee), 12'(|st && !mv[0]));
        chk(12'(n_done - de), 12'(!(|st) || mv[0]));
        if (!full) held = mv[2] ? d : (d & MASK_7);
        full = 1'b1;
        rd(ADDR_STATUS, rv);
        chk({4'h0, rv}, {4'h0, st});
        if (rdb) begin
            rd(ADDR_DATA, rv);
            chk({4'h0, rv}, {4'h0, held});
            full = 1'b0;
            rd(ADDR_STATUS, rv);
            chk({4'h0, rv}, 12'h000);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata, full} = '0;
        xt4_tick = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_MODE, rv);
        chk({4'h0, rv}, {4'h0, MODE_RESET});
        rd(ADDR_BAUD, rv);
        chk({4'h0, rv}, {4'h0, BAUD_RESET});
        rd(ADDR_STATUS, rv);
        chk({4'h0, rv}, {4'h0, STATUS_RESET});
        rd(16'hff9f, rv);
        chk({4'h0, rv}, 12'h000);
        wr(ADDR_BAUD, 8'hff);
        rd(ADDR_BAUD, rv);
        chk({4'h0, rv}, 12'h0df);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_MODE, {i < 4, i[1:0], 5'h00});
            repeat (2) @(posedge clk);
            chk(12'({serial_tx_pin, tx_serial_sel, rx_serial_sel}), 12'({i < 4, i[1] && i < 4, i[0]}));
        end
        $display("test pins done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            sel = (i / 2) % 4;
            k = 8 + r[1:0];
            m = {3'b110, i[1:0], r[2], r[3], 1'b0};
            // p is the divider input period in clocks; the first tick phase can trim the start bit by up to p
            p = (sel == 0) ? 1 : 4 << (sel - 1);
            bc = 2 * k * p;
            cfg(m, {sel[1:0], 1'b0, k[4:0]});
            fb = frame(r[15:8], m, nb);
            wr(ADDR_DATA, r[15:8]);
            i_station.catch(nb, bc, got);
            chk(got, fb);
            w = 0;
            while (transmit_done_irq !== 1'b1 && w < bc) begin
                @(posedge clk);
                w++;
            end
            chk(12'(w >= bc / 2 - p && w < bc / 2), 12'h001);
        end
        $display("test transmit done");
        bc = 64;
        cfg(8'h00, 8'h48);
        rx_case({3'h7, 5'h1c}, 1'b0, 1'b0, 1'b1);
        rx_case({3'h7, 5'h14}, 1'b1, 1'b0, 1'b1);
        rx_case({3'h7, 5'h04}, 1'b0, 1'b1, 1'b1);
        rx_case({3'h7, 5'h1d}, 1'b1, 1'b0, 1'b1);
        rx_case({3'h7, 5'h12}, 1'b0, 1'b0, 1'b0);
        rx_case({3'h7, 5'h0a}, 1'b1, 1'b0, 1'b0);
        rx_case({3'h7, 5'h0d}, 1'b0, 1'b0, 1'b1);
        // a low pulse shorter than half a bit must be rejected at the resample
        w = n_done + n_err;
        i_station.send(12'h000, 1, bc / 4);
        repeat (12 * bc) @(posedge clk);
        chk(12'(n_done + n_err - w), 12'h000);
        $display("test receive done");
        close_out();
    end
endmodule // uac_core_tb
